// ===== verilog/crg_pkg.sv
// crg_pkg: constants for the clock, ready and reset generator
// assumes a 32-bit axi4-lite register bus and 12-bit byte addresses
package crg_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int CRG_AW = 12;
    localparam logic [11:0] CRG_CTRL_OFS = 12'h000;
    localparam logic [11:0] CRG_STATUS_OFS = 12'h004;
    localparam logic [11:0] CRG_CYCLES_OFS = 12'h008;

    // ctrl fields and reset value
    localparam int CRG_CTRL_FRST_BIT = 0;
    localparam logic CRG_CTRL_FRST_RST = 1'b0;

    // status fields
    localparam int CRG_ST_READY_BIT = 0;
    localparam int CRG_ST_PCLK_BIT = 1;
    localparam int CRG_ST_HALF_BIT = 2;
    localparam int CRG_ST_RESET_BIT = 3;
    localparam int CRG_ST_STRAP_BIT = 4;
    localparam int CRG_ST_SEL_BIT = 5;

    // ---------------------------------------------------------------
    // divider and output reset values
    // ---------------------------------------------------------------
    localparam logic [1:0] CRG_DIV_FIRST = 2'h0;
    localparam logic [1:0] CRG_DIV_LAST = 2'h2;
    localparam logic CRG_PCLK_RST = 1'b1;
    localparam logic CRG_RESET_RST = 1'b1;
    localparam logic [31:0] CRG_CYCLES_RST = 32'h0000_0000;

    // ---------------------------------------------------------------
    // pin synchroniser lanes
    // ---------------------------------------------------------------
    localparam int CRG_NPIN = 10;
    localparam int CRG_P_XTAL = 0;
    localparam int CRG_P_EFI = 1;
    localparam int CRG_P_STRAP = 2;
    localparam int CRG_P_CLEAR = 3;
    localparam int CRG_P_SEL = 4;
    localparam int CRG_P_Q1N = 5;
    localparam int CRG_P_Q2N = 6;
    localparam int CRG_P_D1 = 7;
    localparam int CRG_P_D2 = 8;
    localparam int CRG_P_PORN = 9;
    // qualifiers idle high, select pulled high, power-on clear asserted
    localparam logic [9:0] CRG_PIN_RST = 10'h070;

    // ---------------------------------------------------------------
    // axi responses
    // ---------------------------------------------------------------
    localparam logic [1:0] CRG_RESP_OKAY = 2'h0;
    localparam logic [1:0] CRG_RESP_SLVERR = 2'h2;

endpackage : crg_pkg

// ===== verilog/crg_sync.sv
// crg_sync: two-flop synchroniser for a bundle of pin inputs
// assumes every lane is unrelated and may change at any time
`timescale 1ns/10ps
module crg_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // lanes
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    assign sync = sync_q;

endmodule : crg_sync

// ===== verilog/crg_top.sv
// crg_top: processor clock divider, ready synchroniser and reset driver
// assumes pins are asynchronous to ref_clk and far slower than it
`timescale 1ns/10ps
module crg_top
    import crg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // clock sources, strap and phase clear
    input wire logic crystal_pins,
    input wire logic external_freq_in,
    input wire logic source_select_strap,
    input wire logic phase_align_clear,
    // ready inputs and power-on clear
    input wire logic sync_stage_select,
    input wire logic bus1_qualify_n,
    input wire logic bus2_qualify_n,
    input wire logic bus1_done,
    input wire logic bus2_done,
    input wire logic power_on_clear_in_n,
    // generated outputs
    output logic proc_clk,
    output logic peripheral_half_clock,
    output logic crystal_buffer_out,
    output logic ready,
    output logic proc_reset,
    // axi4-lite write
    input wire logic [CRG_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [CRG_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic src_prev;
        logic [1:0] div;
        logic pclk;
        logic half;
        logic ff1;
        logic ff2;
        logic reset;
        logic osc;
        logic frst;
        logic [31:0] cycles;
        logic aw_got;
        logic [CRG_AW-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } crg_state_type;

    crg_state_type s_q;
    crg_state_type s_d;

    logic [CRG_NPIN-1:0] pin_s;
    logic src;
    logic src_rise;
    logic clk_rise;
    logic clk_fall;
    logic qual;
    logic one_stage;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    crg_sync #(
        .WIDTH(CRG_NPIN),
        .INIT(CRG_PIN_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin({power_on_clear_in_n, bus2_done, bus1_done, bus2_qualify_n,
              bus1_qualify_n, sync_stage_select, phase_align_clear,
              source_select_strap, external_freq_in, crystal_pins}),
        .sync(pin_s)
    );

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    function automatic logic reg_hit(input logic [CRG_AW-1:0] a);
        reg_hit = (a == CRG_CTRL_OFS) || (a == CRG_STATUS_OFS) ||
                  (a == CRG_CYCLES_OFS);
    endfunction : reg_hit

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // strap picks the divider source
        src = pin_s[CRG_P_STRAP] ? pin_s[CRG_P_EFI] : pin_s[CRG_P_XTAL];
        src_rise = src && !s_q.src_prev;
        s_d.src_prev = src;
        s_d.osc = pin_s[CRG_P_XTAL];
        if (pin_s[CRG_P_CLEAR]) begin
            s_d.div = CRG_DIV_FIRST;
        end else if (src_rise) begin
            if (s_q.div == CRG_DIV_LAST) begin
                s_d.div = CRG_DIV_FIRST;
            end else begin
                s_d.div = s_q.div + 2'h1;
            end
        end
        s_d.pclk = (s_d.div == CRG_DIV_FIRST);
        clk_rise = s_d.pclk && !s_q.pclk;
        clk_fall = !s_d.pclk && s_q.pclk;
        qual = (pin_s[CRG_P_D1] && !pin_s[CRG_P_Q1N]) ||
               (pin_s[CRG_P_D2] && !pin_s[CRG_P_Q2N]);
        one_stage = pin_s[CRG_P_SEL];
        if (clk_rise) begin
            s_d.ff1 = qual;
            s_d.cycles = s_q.cycles + 32'h0000_0001;
        end
        if (clk_fall) begin
            // select is re-read at every fall
            if (one_stage) begin
                s_d.ff2 = qual;
            end else begin
                s_d.ff2 = s_q.ff1 && qual;
            end
            s_d.half = !s_q.half;
            s_d.reset = !pin_s[CRG_P_PORN] || s_q.frst;
        end
        // write channel
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_d.aw_got && s_d.w_got && !s_d.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = reg_hit(s_d.awaddr) ? CRG_RESP_OKAY : CRG_RESP_SLVERR;
            if (s_d.awaddr == CRG_CTRL_OFS && s_d.wstrb[0]) begin
                s_d.frst = s_d.wdata[CRG_CTRL_FRST_BIT];
            end
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;
        // read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = reg_hit(s_axi_araddr) ? CRG_RESP_OKAY : CRG_RESP_SLVERR;
            s_d.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                CRG_CTRL_OFS: begin
                    s_d.rdata[CRG_CTRL_FRST_BIT] = s_q.frst;
                end
                CRG_STATUS_OFS: begin
                    s_d.rdata[CRG_ST_READY_BIT] = s_q.ff2;
                    s_d.rdata[CRG_ST_PCLK_BIT] = s_q.pclk;
                    s_d.rdata[CRG_ST_HALF_BIT] = s_q.half;
                    s_d.rdata[CRG_ST_RESET_BIT] = s_q.reset;
                    s_d.rdata[CRG_ST_STRAP_BIT] = pin_s[CRG_P_STRAP];
                    s_d.rdata[CRG_ST_SEL_BIT] = pin_s[CRG_P_SEL];
                end
                CRG_CYCLES_OFS: begin
                    s_d.rdata = s_q.cycles;
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        s_d.arready = !s_d.rvalid;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.div <= CRG_DIV_FIRST;
            s_q.pclk <= CRG_PCLK_RST;
            s_q.reset <= CRG_RESET_RST;
            s_q.frst <= CRG_CTRL_FRST_RST;
            s_q.cycles <= CRG_CYCLES_RST;
            s_q.bresp <= CRG_RESP_OKAY;
            s_q.rresp <= CRG_RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign proc_clk = s_q.pclk;
    assign peripheral_half_clock = s_q.half;
    assign crystal_buffer_out = s_q.osc;
    assign ready = s_q.ff2;
    assign proc_reset = s_q.reset;
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence fall_ev;
        clk_fall;
    endsequence

    sequence two_fall_hi;
        fall_ev and (!one_stage && s_q.ff1 && qual);
    endsequence

    gate_block_a: assert property (
        clk_rise && !qual |=> !s_q.ff1)
        else $error("ff1 set without qualified done");
    two_stage_a: assert property (
        fall_ev and (!one_stage && !s_q.ff1) |=> !ready)
        else $error("ready rose without first stage");
    two_rise_a: assert property (
        two_fall_hi |=> ready ##1 (ready || $past(clk_fall)))
        else $error("ready missed two-stage rise");
    fall_direct_a: assert property (
        fall_ev and !qual |=> !ready)
        else $error("ready stayed high after done fell");
    single_stage_a: assert property (
        fall_ev and (one_stage && qual) |=> ready)
        else $error("single stage did not pass done");
    ready_hold_a: assert property (
        !clk_fall |=> $stable(ready))
        else $error("ready changed off a clock fall");
    div_wrap_a: assert property (
        src_rise && !pin_s[CRG_P_CLEAR] && s_q.div == CRG_DIV_LAST
        |=> proc_clk ##0 s_q.div == CRG_DIV_FIRST)
        else $error("divider did not wrap after three");
    duty_a: assert property (
        proc_clk |-> s_q.div == CRG_DIV_FIRST)
        else $error("clock high outside first third");
    osc_follow_a: assert property (
        ##1 crystal_buffer_out == $past(pin_s[CRG_P_XTAL]))
        else $error("oscillator buffer lags");
    half_toggle_a: assert property (
        clk_fall |=> peripheral_half_clock != $past(peripheral_half_clock))
        else $error("half clock missed a toggle");
    clear_hold_a: assert property (
        pin_s[CRG_P_CLEAR] [*2] |-> s_q.div == CRG_DIV_FIRST)
        else $error("divider ran during clear");
    reset_drive_a: assert property (
        clk_fall && !pin_s[CRG_P_PORN] |=> proc_reset)
        else $error("reset not raised on clock fall");

endmodule : crg_top

// ===== bench/crg_far_side.sv
// crg_far_side: crystal, external source and phase clear at the far side
// assumes ref_clk is far faster than either source
`timescale 1ns/10ps
module crg_far_side (
    // clock
    input wire logic ref_clk,
    // request from the bench
    input wire logic clear_req,
    // sources
    output logic crystal_pins,
    output logic external_freq_in,
    output logic phase_align_clear
);
    int xtal_cnt = 0;
    int efi_cnt = 0;
    initial begin
        crystal_pins = 1'b0;
        external_freq_in = 1'b0;
        phase_align_clear = 1'b0;
    end
    // crystal period 8 ref_clk, external period 12 ref_clk
    always @(posedge ref_clk) begin
        xtal_cnt <= (xtal_cnt == 3) ? 0 : xtal_cnt + 1;
        if (xtal_cnt == 3) begin
            crystal_pins <= !crystal_pins;
        end
        efi_cnt <= (efi_cnt == 5) ? 0 : efi_cnt + 1;
        if (efi_cnt == 5) begin
            external_freq_in <= !external_freq_in;
            if (!external_freq_in) begin
                phase_align_clear <= clear_req;
            end
        end
    end
endmodule : crg_far_side

// ===== bench/clock_ready_reset_generator_bench.sv
// clock_ready_reset_generator_bench: self-checking bench for crg_top
// assumes crg_far_side supplies both sources and the phase clear
`timescale 1ns/10ps
module clock_ready_reset_generator_bench import crg_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic source_select_strap = 1'b0;
    logic sync_stage_select = 1'b1;
    logic bus1_qualify_n = 1'b0;
    logic bus2_qualify_n = 1'b0;
    logic bus1_done = 1'b0;
    logic bus2_done = 1'b0;
    logic power_on_clear_in_n = 1'b0;
    logic clear_req = 1'b0;
    logic crystal_pins, external_freq_in, phase_align_clear;
    logic proc_clk, peripheral_half_clock, crystal_buffer_out;
    logic ready, proc_reset;
    logic [CRG_AW-1:0] s_axi_awaddr = '0;
    logic [CRG_AW-1:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int err_count = 0;
    int check_count = 0;

    crg_far_side i_far (.ref_clk, .clear_req, .crystal_pins,
        .external_freq_in, .phase_align_clear);
    crg_top i_dut (.ref_clk, .rst, .crystal_pins, .external_freq_in,
        .source_select_strap, .phase_align_clear, .sync_stage_select,
        .bus1_qualify_n, .bus2_qualify_n, .bus1_done, .bus2_done,
        .power_on_clear_in_n, .proc_clk, .peripheral_half_clock,
        .crystal_buffer_out, .ready, .proc_reset, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        forever #2 ref_clk = !ref_clk;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [1:0] er,
        output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        check(s_axi_rresp, er);
    endtask : axi_read

    function automatic logic pick(input int which);
        case (which)
            0: return proc_clk;
            1: return peripheral_half_clock;
            2: return crystal_buffer_out;
            3: return ready;
            default: return proc_reset;
        endcase
    endfunction : pick

    // high time and period of one output, in ref_clk cycles
    task automatic measure(input int which, output int hi, output int per);
        hi = 0;
        @(posedge ref_clk);
        while (pick(which) !== 1'b0) @(posedge ref_clk);
        while (pick(which) !== 1'b1) @(posedge ref_clk);
        while (pick(which) === 1'b1) begin
            hi++;
            @(posedge ref_clk);
        end
        per = hi;
        while (pick(which) === 1'b0) begin
            per++;
            @(posedge ref_clk);
        end
    endtask : measure

    // wait for an output level; count proc_clk rises and cycles since fall
    task automatic track(input int which, input logic lvl, output int rises,
        output int since);
        logic prev;
        rises = 0;
        since = 0;
        prev = proc_clk;
        do begin
            @(posedge ref_clk);
            since++;
            if (prev && !proc_clk) since = 0;
            if (!prev && proc_clk) rises++;
            prev = proc_clk;
        end while (pick(which) !== lvl);
    endtask : track

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_clocks(input logic strap, input int src);
        int hi;
        int per;
        source_select_strap <= strap;
        repeat (9 * src) @(posedge ref_clk);
        measure(0, hi, per);
        check(per, 3 * src);
        check(hi, src);
        measure(1, hi, per);
        check(proc_clk, 1'b0);
        check(per, 6 * src);
        check(hi, 3 * src);
        measure(2, hi, per);
        check(per, 8);
    endtask : test_clocks

    task automatic ready_trial(input logic sel, input logic lvl, input int er);
        int rises;
        int since;
        track(0, 1'b1, rises, since);
        sync_stage_select <= sel;
        bus1_done <= lvl;
        track(3, lvl, rises, since);
        check(rises, er);
        check(since, 0);
    endtask : ready_trial

    task automatic test_qualify;
        bus1_qualify_n <= 1'b1;
        bus2_qualify_n <= 1'b1;
        bus1_done <= 1'b1;
        bus2_done <= 1'b1;
        repeat (80) @(posedge ref_clk);
        check(ready, 1'b0);
        bus2_qualify_n <= 1'b0;
        bus1_done <= 1'b0;
        repeat (80) @(posedge ref_clk);
        check(ready, 1'b1);
        bus1_qualify_n <= 1'b0;
        bus1_done <= 1'b1;
        bus2_done <= 1'b0;
        repeat (80) @(posedge ref_clk);
        check(ready, 1'b1);
        bus1_done <= 1'b0;
        repeat (80) @(posedge ref_clk);
        check(ready, 1'b0);
    endtask : test_qualify

    task automatic test_clear;
        int lows;
        int hi;
        int per;
        // phase clear only changes on external source rises, so the external source is selected
        source_select_strap <= 1'b1;
        clear_req <= 1'b1;
        repeat (30) @(posedge ref_clk);
        lows = 0;
        repeat (100) begin
            @(posedge ref_clk);
            if (proc_clk !== 1'b1) lows++;
        end
        check(lows, 0);
        clear_req <= 1'b0;
        measure(0, hi, per);
        check(per, 36);
        check(hi, 12);
        source_select_strap <= 1'b0;
    endtask : test_clear

    task automatic test_regs;
        logic [31:0] d;
        logic [31:0] d2;
        int rises;
        int since;
        axi_read(CRG_CTRL_OFS, CRG_RESP_OKAY, d);
        check(d, 32'h0000_0000);
        axi_write(CRG_CTRL_OFS, 32'h0000_0001, 4'h0, CRG_RESP_OKAY);
        axi_read(CRG_CTRL_OFS, CRG_RESP_OKAY, d);
        check(d, 32'h0000_0000);
        axi_write(CRG_CTRL_OFS, 32'h0000_0001, 4'hF, CRG_RESP_OKAY);
        track(4, 1'b1, rises, since);
        check(since, 0);
        axi_read(CRG_CTRL_OFS, CRG_RESP_OKAY, d);
        check(d, 32'h0000_0001);
        axi_write(CRG_CTRL_OFS, 32'h0000_0000, 4'hF, CRG_RESP_OKAY);
        track(4, 1'b0, rises, since);
        check(since, 0);
        axi_read(CRG_STATUS_OFS, CRG_RESP_OKAY, d);
        check(d[5:3], 3'h4);
        axi_write(12'h00C, 32'hFFFF_FFFF, 4'hF, CRG_RESP_SLVERR);
        axi_read(12'h00C, CRG_RESP_SLVERR, d);
        check(d, 32'h0000_0000);
        // 240 ref_clk cycles hold exactly ten proc_clk rises
        axi_read(CRG_CYCLES_OFS, CRG_RESP_OKAY, d);
        repeat (238) @(posedge ref_clk);
        axi_read(CRG_CYCLES_OFS, CRG_RESP_OKAY, d2);
        check(d2 - d, 32'h0000_000A);
    endtask : test_regs

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        int rises;
        int since;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (40) @(posedge ref_clk);
        check(proc_reset, 1'b1);
        power_on_clear_in_n <= 1'b1;
        track(4, 1'b0, rises, since);
        check(since, 0);
        test_clocks(1'b1, 12);
        test_clocks(1'b0, 8);
        ready_trial(1'b0, 1'b1, 1);
        ready_trial(1'b0, 1'b0, 0);
        ready_trial(1'b1, 1'b1, 0);
        ready_trial(1'b1, 1'b0, 0);
        test_qualify();
        test_clear();
        test_regs();
        complete_run();
    end

    initial begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule : clock_ready_reset_generator_bench
